//--- jdrs_pkg.sv
// Purpose: Shared constants and types for the debug test port registers
// Assumes: Processor bus is a simple word/halfword strobe port
// Notes:   Offsets are byte addresses within the control register space
package jdrs_pkg;
   // Processor side register offsets
   localparam logic [4:0] JDRS_OFS_INSTR   = 5'h00;
   localparam logic [4:0] JDRS_OFS_DATA_HI = 5'h08;
   localparam logic [4:0] JDRS_OFS_DATA_LO = 5'h0A;
   localparam logic [4:0] JDRS_OFS_INTF    = 5'h14;
   // Instruction layout
   localparam int         JDRS_IR_LEN      = 8;
   localparam logic [7:0] JDRS_IR_BYPASS   = 8'hFF;
   localparam logic [7:0] JDRS_IR_EXTEST   = 8'h00;
   localparam logic [7:0] JDRS_IR_SAMPLE   = 8'h04;
   localparam logic [3:0] JDRS_IR_RST_NEG  = 4'h6;
   localparam logic [3:0] JDRS_IR_RST_ASR  = 4'h7;
   localparam logic [2:0] JDRS_IR_DBG_INT  = 3'h5;
   localparam logic [7:0] JDRS_IR_RSVD     = 8'hFF;
   localparam logic [15:0] JDRS_INTF_RSVD  = 16'h0000;
   localparam logic [15:0] JDRS_HALF_ZERO  = 16'h0000;
   localparam int         JDRS_DR_LEN      = 32;
   // Timing
   localparam int  JDRS_CLK_MHZ     = 50;
   localparam int  JDRS_TCK_MAX_MHZ = 20;
   // TAP controller states
   typedef enum logic [3:0] {
      JDRS_TLR, JDRS_RTI, JDRS_SEL_DR, JDRS_CAP_DR, JDRS_SH_DR, JDRS_EX1_DR,
      JDRS_PA_DR, JDRS_EX2_DR, JDRS_UPD_DR, JDRS_SEL_IR, JDRS_CAP_IR,
      JDRS_SH_IR, JDRS_EX1_IR, JDRS_PA_IR, JDRS_EX2_IR, JDRS_UPD_IR
   } jdrs_tap_t;
   // Processor access
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [1:0]  be;   // [1]=upper half, [0]=lower half
      logic [4:0]  addr;
      logic [31:0] wdata;
   } jdrs_req_t;
   // Decoded instruction
   typedef struct packed {
      logic bypass;
      logic extest;
      logic sample;
      logic rst_neg;
      logic rst_asr;
      logic dbg_int;
   } jdrs_dec_t;
endpackage

//--- jdrs_top.sv
// Purpose: Debug test port register set with TAP, sampled on system clock
// Assumes: Test clock well below system clock; sampled, not a clock domain
// Notes:   Test clock edges are found by two-flop sampling and an edge
//          detector, so the whole block runs on clk_sys_i alone.
`timescale 1ns/1ps
module jdrs_top
   import jdrs_pkg::*;
#(
   parameter int DR_LEN = JDRS_DR_LEN
) (
   // System
   input  wire logic        clk_sys_i,
   input  wire logic        arst_n_i,
   input  wire logic        cpu_rst_n_i,
   // Test port pins
   input  wire logic        tck_i,
   input  wire logic        tms_i,
   input  wire logic        tdi_i,
   input  wire logic        trst_n_i,
   output logic             tdo_o,
   output logic             tdo_oe_o,
   // Boundary scan chain hook
   input  wire logic        bsr_so_i,
   output logic             bsr_si_o,
   output logic             bsr_shift_o,
   output logic             bsr_capture_o,
   output logic             bsr_update_o,
   output logic             bsr_extest_o,
   // Processor access
   input  wire jdrs_req_t   req_i,
   output logic [31:0]      rdata_o,
   output logic             ack_o,
   // Decoded commands
   output logic             dbg_reset_o,
   output logic             dbg_irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] tck_sync_reg, tms_sync_reg, tdi_sync_reg, trst_sync_reg;
   logic       tck_prev_reg;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tck_sync_reg  <= 2'h0;
         tms_sync_reg  <= 2'h3;
         tdi_sync_reg  <= 2'h3;
         trst_sync_reg <= 2'h0;
         tck_prev_reg  <= 1'b0;
      end else begin
         tck_sync_reg  <= {tck_sync_reg[0], tck_i};
         tms_sync_reg  <= {tms_sync_reg[0], tms_i};
         tdi_sync_reg  <= {tdi_sync_reg[0], tdi_i};
         trst_sync_reg <= {trst_sync_reg[0], trst_n_i};
         tck_prev_reg  <= tck_sync_reg[1];
      end
   end

   wire tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
   wire tck_fall = ~tck_sync_reg[1] & tck_prev_reg;
   wire tms      = tms_sync_reg[1];
   wire tdi      = tdi_sync_reg[1];
   // Test reset seen synchronously; the async pin path would need its
   // own reset tree, so it is folded into the sampled domain instead
   wire trst_act = ~trst_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////////
   // TAP controller
   jdrs_tap_t tap_reg, tap_next;

   always_comb begin
      tap_next = tap_reg;
      case (tap_reg)
         JDRS_TLR:    tap_next = tms ? JDRS_TLR    : JDRS_RTI;
         JDRS_RTI:    tap_next = tms ? JDRS_SEL_DR : JDRS_RTI;
         JDRS_SEL_DR: tap_next = tms ? JDRS_SEL_IR : JDRS_CAP_DR;
         JDRS_CAP_DR: tap_next = tms ? JDRS_EX1_DR : JDRS_SH_DR;
         JDRS_SH_DR:  tap_next = tms ? JDRS_EX1_DR : JDRS_SH_DR;
         JDRS_EX1_DR: tap_next = tms ? JDRS_UPD_DR : JDRS_PA_DR;
         JDRS_PA_DR:  tap_next = tms ? JDRS_EX2_DR : JDRS_PA_DR;
         JDRS_EX2_DR: tap_next = tms ? JDRS_UPD_DR : JDRS_SH_DR;
         JDRS_UPD_DR: tap_next = tms ? JDRS_SEL_DR : JDRS_RTI;
         JDRS_SEL_IR: tap_next = tms ? JDRS_TLR    : JDRS_CAP_IR;
         JDRS_CAP_IR: tap_next = tms ? JDRS_EX1_IR : JDRS_SH_IR;
         JDRS_SH_IR:  tap_next = tms ? JDRS_EX1_IR : JDRS_SH_IR;
         JDRS_EX1_IR: tap_next = tms ? JDRS_UPD_IR : JDRS_PA_IR;
         JDRS_PA_IR:  tap_next = tms ? JDRS_EX2_IR : JDRS_PA_IR;
         JDRS_EX2_IR: tap_next = tms ? JDRS_UPD_IR : JDRS_SH_IR;
         JDRS_UPD_IR: tap_next = tms ? JDRS_SEL_DR : JDRS_RTI;
         default:     tap_next = JDRS_TLR;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i)
         tap_reg <= JDRS_TLR;
      else if (trst_act)
         tap_reg <= JDRS_TLR;
      else if (tck_rise)
         tap_reg <= tap_next;
   end

   wire tlr      = (tap_reg == JDRS_TLR);
   wire init     = trst_act | tlr;
   wire sh_ir    = (tap_reg == JDRS_SH_IR);
   wire sh_dr    = (tap_reg == JDRS_SH_DR);
   wire cap_ir   = (tap_reg == JDRS_CAP_IR);
   wire cap_dr   = (tap_reg == JDRS_CAP_DR);
   wire upd_ir_f = (tap_reg == JDRS_UPD_IR) & tck_fall;
   wire upd_dr_f = (tap_reg == JDRS_UPD_DR) & tck_fall;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction register
   logic [JDRS_IR_LEN-1:0] ir_sh_reg, ir_reg;
   jdrs_dec_t              dec, upd_dec;

   // Serial path only; no processor write reaches these flops
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ir_sh_reg <= JDRS_IR_BYPASS;
         ir_reg    <= JDRS_IR_BYPASS;
      end else if (init) begin
         ir_sh_reg <= JDRS_IR_BYPASS;
         ir_reg    <= JDRS_IR_BYPASS;
      end else begin
         if (tck_rise && cap_ir)
            ir_sh_reg <= ir_reg;
         else if (tck_rise && sh_ir)
            ir_sh_reg <= {tdi, ir_sh_reg[JDRS_IR_LEN-1:1]};
         if (upd_ir_f)
            ir_reg <= ir_sh_reg;
      end
   end

   // Reserved codes fall through to bypass behaviour
   function automatic jdrs_dec_t decode(input logic [7:0] c);
      jdrs_dec_t d;
      d.bypass  = (c == JDRS_IR_BYPASS);
      d.extest  = (c == JDRS_IR_EXTEST);
      d.sample  = (c == JDRS_IR_SAMPLE);
      d.rst_neg = (c[7:4] == JDRS_IR_RST_NEG);
      d.rst_asr = (c[7:4] == JDRS_IR_RST_ASR);
      d.dbg_int = (c[7:5] == JDRS_IR_DBG_INT);
      return d;
   endfunction

   assign dec     = decode(ir_reg);
   assign upd_dec = decode(ir_sh_reg);
   wire   bsr_sel = dec.extest | dec.sample;

   ////////////////////////////////////////////////////////////////////////////
   // Scan data registers
   logic              byp_reg;
   logic [DR_LEN-1:0] intf_sh_reg;
   logic              irq_flag_reg;
   logic              dbg_reset_reg;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         byp_reg     <= 1'b0;
         intf_sh_reg <= '0;
      end else if (tck_rise && sh_dr && dec.dbg_int) begin
         intf_sh_reg <= {tdi, intf_sh_reg[DR_LEN-1:1]};
      end else if (tck_rise && cap_dr && dec.dbg_int) begin
         intf_sh_reg <= {JDRS_HALF_ZERO,
                         JDRS_INTF_RSVD[15:1], irq_flag_reg};
      end else if (tck_rise && (sh_dr || cap_dr)) begin
         byp_reg <= sh_dr & tdi;
      end
   end

   // Output mux, launched on the falling test clock edge
   logic tdo_mux;
   always_comb begin
      tdo_mux = byp_reg;
      if (sh_ir)
         tdo_mux = ir_sh_reg[0];
      else if (dec.dbg_int)
         tdo_mux = intf_sh_reg[0];
      else if (bsr_sel)
         tdo_mux = bsr_so_i;
      else if (dec.bypass)
         tdo_mux = byp_reg;
      // Reserved codes also see the bypass bit, so the chain stays
      // one stage long and a host can still count the devices
      else
         tdo_mux = byp_reg;
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tdo_o    <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else if (tck_fall) begin
         tdo_o    <= tdo_mux;
         tdo_oe_o <= sh_ir | sh_dr;
      end
   end

   assign bsr_si_o      = tdi;
   assign bsr_shift_o   = tck_rise & sh_dr & bsr_sel;
   assign bsr_capture_o = tck_rise & cap_dr & bsr_sel;
   assign bsr_update_o  = upd_dr_f & bsr_sel;
   assign bsr_extest_o  = dec.extest;

   ////////////////////////////////////////////////////////////////////////////
   // Processor registers
   logic [DR_LEN-1:0] data_reg;
   wire hit_instr = (req_i.addr == JDRS_OFS_INSTR);
   wire hit_hi    = (req_i.addr == JDRS_OFS_DATA_HI);
   wire hit_lo    = (req_i.addr == JDRS_OFS_DATA_LO);
   wire hit_intf  = (req_i.addr == JDRS_OFS_INTF);
   wire wr_hi     = req_i.wr & hit_hi & req_i.be[1];
   wire wr_lo     = req_i.wr & ((hit_hi & req_i.be[0]) | (hit_lo & req_i.be[1]));
   wire lo_src_hi = hit_lo;
   wire clr_flag  = req_i.wr & hit_intf & ~req_i.wdata[0];
   wire set_flag  = upd_ir_f & upd_dec.dbg_int;

   // Data word: test reset only; processor reset does not touch it
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i)
         data_reg <= '0;
      else if (trst_act)
         data_reg <= '0;
      else begin
         if (wr_hi)
            data_reg[31:16] <= req_i.wdata[31:16];
         if (wr_lo)
            data_reg[15:0] <= lo_src_hi ? req_i.wdata[31:16]
                                        : req_i.wdata[15:0];
      end
   end

   // Flag set beats clear in the same cycle
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i)
         irq_flag_reg <= 1'b0;
      else if (init)
         irq_flag_reg <= 1'b0;
      else if (set_flag)
         irq_flag_reg <= 1'b1;
      else if (clr_flag)
         irq_flag_reg <= 1'b0;
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i)
         dbg_reset_reg <= 1'b0;
      else if (init)
         dbg_reset_reg <= 1'b0;
      else if (dec.rst_asr)
         dbg_reset_reg <= 1'b1;
      else if (dec.rst_neg)
         dbg_reset_reg <= 1'b0;
   end

   // Read mux; unmapped offsets read zero
   wire [15:0] instr_rd = {ir_reg, JDRS_IR_RSVD};
   wire [15:0] intf_rd  = {JDRS_INTF_RSVD[15:1], irq_flag_reg};
   wire [31:0] rd_mux   = hit_instr ? {instr_rd, instr_rd} :
                          hit_hi    ? data_reg :
                          hit_lo    ? {data_reg[15:0], data_reg[15:0]} :
                          hit_intf  ? {intf_rd, intf_rd} : 32'h0000_0000;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= 32'h0000_0000;
         ack_o   <= 1'b0;
      end else begin
         rdata_o <= req_i.rd ? rd_mux : 32'h0000_0000;
         ack_o   <= (req_i.rd | req_i.wr) & cpu_rst_n_i;
      end
   end

   assign dbg_irq_o   = irq_flag_reg;
   assign dbg_reset_o = dbg_reset_reg;

endmodule // jdrs_top

//--- jdrs_properties.sv
// Purpose: Port checker for the debug register set
// Assumes: One clock domain, async active-low reset
// Notes:   Bound onto every jdrs_top instance
`timescale 1ns/1ps
module jdrs_properties
   import jdrs_pkg::*;
(
   // System
   input wire logic        clk_sys_i,
   input wire logic        arst_n_i,
   input wire logic        cpu_rst_n_i,
   input wire logic        trst_n_i,
   input wire logic        tck_i,
   // Processor side
   input wire jdrs_req_t   req_i,
   input wire logic [31:0] rdata_o,
   input wire logic        ack_o,
   // Decoded commands
   input wire logic        bsr_extest_o,
   input wire logic        dbg_reset_o,
   input wire logic        dbg_irq_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   //////////////////////////////////////////
   wire logic strobe = (req_i.rd | req_i.wr) & cpu_rst_n_i;
   wire logic rd_ins = req_i.rd & (req_i.addr == JDRS_OFS_INSTR);
   wire logic rd_int = req_i.rd & (req_i.addr == JDRS_OFS_INTF);
   wire logic mapped = req_i.addr inside {JDRS_OFS_INSTR,
      JDRS_OFS_DATA_HI, JDRS_OFS_DATA_LO, JDRS_OFS_INTF};
   // Set wins over clear, so a tck update in this cycle can mask it
   wire logic clr = req_i.wr & cpu_rst_n_i & (req_i.be == 2'b11)
      & (req_i.addr == JDRS_OFS_INTF) & (req_i.wdata == 32'h0);
   property p_ack; strobe |=> ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_ack_cause; ack_o |-> $past(req_i.rd | req_i.wr); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_rd_ins;
      rd_ins |=> rdata_o[7:0] == 8'hFF && rdata_o[23:16] == 8'hFF;
   endproperty
   a_rd_ins: assert property (p_rd_ins) else $error("ir low byte");
   property p_rd_flag;
      rd_int |=> rdata_o[15:1] == 15'h0 && rdata_o[0] == $past(dbg_irq_o);
   endproperty
   a_rd_flag: assert property (p_rd_flag) else $error("flag read");
   property p_extest; rd_ins && bsr_extest_o |=> rdata_o[15:8] == 8'h00;
   endproperty
   a_extest: assert property (p_extest) else $error("extest code");
   property p_unmap; req_i.rd && !mapped |=> rdata_o == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_trst; !trst_n_i [*5] |-> !dbg_irq_o && !bsr_extest_o;
   endproperty
   a_trst: assert property (p_trst) else $error("test reset");
   // Skip cycles in which a sampled test clock fall may land an update
   property p_clr;
      clr && !($past(tck_i, 3) && !$past(tck_i, 2)) |=> !dbg_irq_o;
   endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   cover property (rd_int ##1 rdata_o[0]);
   cover property (bsr_extest_o);
   cover property (dbg_reset_o);
endmodule // jdrs_properties

bind jdrs_top jdrs_properties u_prop (.*);

//--- jdrs_jtag_host.sv
// Purpose: Behavioural external test controller
// Assumes: tck idles low between frames
// Notes:   tdi returns high between frames, as a pulled-up pin would
`timescale 1ns/1ps
module jdrs_jtag_host (
   // Test port
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   input  wire logic tdo_i
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end
   //////////////////////////////////////////
   // 160 ns period, below 20 MHz and the system clock
   task automatic step(input logic m, d, output logic q);
      tms_o = m;
      tdi_o = d;
      #80;
      q = tdo_i;
      tck_o = 1'b1;
      #80;
      tck_o = 1'b0;
   endtask
   // Callers pass only defined instruction codes
   task automatic scan(input logic ir, input int n,
                       input logic [31:0] d, output logic [31:0] o);
      logic q;
      o = 32'h0;
      step(1'b0, 1'b1, q);
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, d[i], q);
         o[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask
   task automatic reset_tap;
      logic q;
      repeat (5) step(1'b1, 1'b1, q);
   endtask
endmodule // jdrs_jtag_host

//--- jtag_debug_register_set_test.sv
// Purpose: Self-checking bench for the debug register set
// Assumes: Inputs change 2 ns after the rising clock edge
// Notes:   Data word reset value is the designer's choice of zero
`timescale 1ns/1ps
module jtag_debug_register_set_test;
   import jdrs_pkg::*;
   logic        clk_sys_i, arst_n_i, cpu_rst_n_i, trst_n_i;
   logic        tck, tms, tdi, tdo;
   logic [31:0] rdata_o, q;
   logic        ack_o, bsr_extest_o, dbg_reset_o, dbg_irq_o;
   logic        bsr_si, bsr_shift, bsr_capture, bsr_update, tdo_oe;
   logic        bsr_so = 1'b0;
   jdrs_req_t   req = '0;
   int          num_errors = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   int          n_shift = 0, n_capture = 0, n_update = 0, n_oe = 0;
   jdrs_jtag_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
   jdrs_top DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .cpu_rst_n_i(cpu_rst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .trst_n_i(trst_n_i), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
      .bsr_so_i(bsr_so), .bsr_si_o(bsr_si), .bsr_shift_o(bsr_shift),
      .bsr_capture_o(bsr_capture), .bsr_update_o(bsr_update),
      .bsr_extest_o(bsr_extest_o), .req_i(req), .rdata_o(rdata_o),
      .ack_o(ack_o), .dbg_reset_o(dbg_reset_o), .dbg_irq_o(dbg_irq_o));
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   // Hang guard, well above the roughly 1600 cycles needed
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         summarize();
      end
   end
   // One-cell boundary chain stand-in; capture loads a one
   always @(posedge clk_sys_i) begin
      if (bsr_capture)
         bsr_so <= 1'b1;
      else if (bsr_shift)
         bsr_so <= bsr_si;
      n_shift   += bsr_shift;
      n_capture += bsr_capture;
      n_update  += bsr_update;
      n_oe      += tdo_oe;
   end
   //////////////////////////////////////////
   task automatic check(input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic r, w, input logic [1:0] b,
                      input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      #2;
      req = '{r, w, b, a, d};
      @(posedge clk_sys_i);
      #2;
      req = '0;
      q = rdata_o;
      check({31'h0, ack_o}, 32'h1);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      bus(1'b1, 1'b0, 2'b11, a, 32'h0);
      check(q, e);
   endtask
   task automatic summarize;
      $display("errors=%0d compares=%0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   //////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] o;
      rd(JDRS_OFS_INSTR, 32'hFFFFFFFF);
      rd(JDRS_OFS_INTF, 32'h0);
      bus(1'b0, 1'b1, 2'b11, JDRS_OFS_INSTR, 32'h0);
      rd(JDRS_OFS_INSTR, 32'hFFFFFFFF);
      host.reset_tap();
      host.scan(1'b0, 4, 32'hA, o);
      check(o, 32'h4);
   endtask
   task automatic t_data;
      bus(1'b0, 1'b1, 2'b11, JDRS_OFS_DATA_HI, 32'h12345678);
      bus(1'b0, 1'b1, 2'b10, JDRS_OFS_DATA_LO, 32'hA5A50000);
      rd(JDRS_OFS_DATA_HI, 32'h1234A5A5);
      bus(1'b0, 1'b1, 2'b10, JDRS_OFS_DATA_HI, 32'hBEEF0000);
      rd(JDRS_OFS_DATA_LO, 32'hA5A5A5A5);
      cpu_rst_n_i = 1'b0;
      repeat (3) @(posedge clk_sys_i);
      #2;
      cpu_rst_n_i = 1'b1;
      rd(JDRS_OFS_DATA_HI, 32'hBEEFA5A5);
      rd(5'h04, 32'h0);
   endtask
   task automatic t_irq;
      logic [31:0] o;
      cpu_rst_n_i = 1'b0;
      host.scan(1'b1, 8, 32'hA0, o);
      cpu_rst_n_i = 1'b1;
      check({31'h0, dbg_irq_o}, 32'h1);
      rd(JDRS_OFS_INSTR, 32'hA0FFA0FF);
      host.scan(1'b0, 32, 32'h0, o);
      check(o, 32'h1);
      bus(1'b0, 1'b1, 2'b11, JDRS_OFS_INTF, 32'h1);
      check({31'h0, dbg_irq_o}, 32'h1);
      bus(1'b0, 1'b1, 2'b11, JDRS_OFS_INTF, 32'h0);
      check({31'h0, dbg_irq_o}, 32'h0);
   endtask
   task automatic t_codes;
      logic [7:0]  c [4] = '{8'h00, 8'h04, 8'h70, 8'h60};
      logic [1:0]  e [4] = '{2'b10, 2'b00, 2'b01, 2'b00};
      logic [31:0] o;
      for (int i = 0; i < 4; i++) begin
         host.scan(1'b1, 8, {24'h0, c[i]}, o);
         rd(JDRS_OFS_INSTR, {2{c[i], 8'hFF}});
         check({30'h0, bsr_extest_o, dbg_reset_o}, {30'h0, e[i]});
      end
   endtask
   task automatic t_tlr;
      logic [31:0] o;
      host.scan(1'b1, 8, 32'hA0, o);
      host.reset_tap();
      rd(JDRS_OFS_INSTR, 32'hFFFFFFFF);
      rd(JDRS_OFS_INTF, 32'h0);
      host.scan(1'b1, 8, 32'hA0, o);
      trst_n_i = 1'b0;
      repeat (5) @(posedge clk_sys_i);
      #2;
      trst_n_i = 1'b1;
      rd(JDRS_OFS_INSTR, 32'hFFFFFFFF);
      rd(JDRS_OFS_INTF, 32'h0);
      rd(JDRS_OFS_DATA_HI, 32'h0);
   endtask
   task automatic t_bsr;
      logic [31:0] o;
      int          s, c, u, e;
      host.scan(1'b1, 8, {24'h0, JDRS_IR_SAMPLE}, o);
      s = n_shift;
      c = n_capture;
      u = n_update;
      e = n_oe;
      host.scan(1'b0, 6, 32'h2C, o);
      check(o, 32'h19);
      check(n_capture - c, 1);
      check(n_shift - s, 6);
      check(n_update - u, 1);
      check(n_oe - e, 48);
      check({31'h0, tdo_oe}, 32'h0);
   endtask
   //////////////////////////////////////////
   initial begin
      arst_n_i = 1'b0;
      trst_n_i = 1'b0;
      cpu_rst_n_i = 1'b1;
      repeat (12) @(posedge clk_sys_i);
      #2;
      arst_n_i = 1'b1;
      trst_n_i = 1'b1;
      t_reset();
      t_data();
      t_irq();
      t_codes();
      t_tlr();
      t_bsr();
      summarize();
   end
endmodule // jtag_debug_register_set_test
